// File: logic/efdc_pkg.sv
// Purpose: Constants and carriers for the auxiliary FIFO transfer control block
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes:   Register indices are kept; byte address is four times the index
package efdc_pkg;

  // Register indices and byte addresses
  localparam logic [9:0]  CMD_INDEX     = 10'h064;
  localparam logic [9:0]  STAT_INDEX    = 10'h06e;
  localparam logic [9:0]  NOTIFY_INDEX  = 10'h070;
  localparam logic [9:0]  BUFLEN_INDEX  = 10'h071;
  localparam logic [9:0]  TMO_INDEX     = 10'h072;
  localparam logic [9:0]  AVAIL_INDEX   = 10'h073;
  localparam logic [9:0]  RELEASE_INDEX = 10'h074;
  localparam logic [9:0]  IRQ_STAT_INDEX = 10'h075;
  localparam logic [9:0]  IRQ_MASK_INDEX = 10'h076;
  localparam logic [11:0] A_CMD      = {CMD_INDEX, 2'h0};
  localparam logic [11:0] A_STAT     = {STAT_INDEX, 2'h0};
  localparam logic [11:0] A_NOTIFY   = {NOTIFY_INDEX, 2'h0};
  localparam logic [11:0] A_BUFLEN   = {BUFLEN_INDEX, 2'h0};
  localparam logic [11:0] A_TMO      = {TMO_INDEX, 2'h0};
  localparam logic [11:0] A_AVAIL    = {AVAIL_INDEX, 2'h0};
  localparam logic [11:0] A_RELEASE  = {RELEASE_INDEX, 2'h0};
  localparam logic [11:0] A_IRQ_STAT = {IRQ_STAT_INDEX, 2'h0};
  localparam logic [11:0] A_IRQ_MASK = {IRQ_MASK_INDEX, 2'h0};

  // Command word bit positions
  localparam int unsigned CMD_START = 20;
  localparam int unsigned CMD_WAIT  = 21;
  localparam int unsigned CMD_ABORT = 22;
  localparam int unsigned CMD_POLL  = 23;
  localparam logic [31:0] CMD_AUX_MASK = 32'h00f0_0000;

  // Status word: aux flags occupy bits 15..12
  localparam int unsigned  STAT_LSB      = 12;
  localparam logic [31:0]  STAT_AUX_MASK = 32'h0000_f000;

  // Reset values and sizes
  localparam logic [31:0] ZERO32      = 32'h0000_0000;
  localparam logic [31:0] BEAT_BYTES  = 32'h0000_0004;
  localparam logic [4:0]  IRQ_MASK_RST = 5'h00;

  typedef struct packed {
    logic fault;
    logic overrun;
    logic done;
    logic block_ready;
  } efdc_stat_s;

  typedef struct packed {
    logic timeout;
    logic fault;
    logic overrun;
    logic done;
    logic block_ready;
  } efdc_irq_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DMA  = 3'b010,
    ST_POLL = 3'b100
  } efdc_state_e;

endpackage : efdc_pkg

// File: logic/efdc_ctrl.sv
// Purpose: Command and status control of the auxiliary FIFO transfer channel
// Assumes: Engine signals come from logic on pclk; APB master per protocol
// Notes:   A write carrying the wait bit holds pready low until it may end
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Aux control shares command and status words
// - Combined command bits: abort outranks start, start outranks poll
// - Command word executes, stores nothing
// - Start bit launches busmaster transfer
// - Wait bit blocks until done, block, overrun or fault
// - Wait ends early on programmed timeout
// - Abort stops transfer, buffer becomes invalid
// - Poll bit selects on-request read out
// - Status word read-only, shows current flags
// - Block ready when notify bytes available
// - Done flag only with zero notify
// - Overrun flag on FIFO overrun
// - Fault flag on internal error
// - Overrun halts transfer at once
// - Card to host only, no offset
module efdc_ctrl
  import efdc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pclken,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Shared card and sample side
  input  wire logic [31:0] main_status,
  output logic             card_cmd_valid,
  output logic [31:0]      card_cmd,
  // Busmaster engine
  input  wire logic        eng_beat,
  input  wire logic        eng_overrun,
  input  wire logic        eng_fault,
  output logic             aux_run,
  output logic             aux_poll_mode,
  output logic             aux_poll_req,
  output logic             aux_room,
  output logic             aux_flush,
  // Interrupt
  output logic             irq
);

  efdc_state_e state;
  efdc_state_e next_state;
  efdc_stat_s  st;
  efdc_stat_s  next_st;
  efdc_irq_s   irq_stat;
  efdc_irq_s   irq_ev;
  logic [4:0]  irq_mask;
  logic [31:0] notify_size;
  logic [31:0] buf_len;
  logic [31:0] tmo_cycles;
  logic [31:0] tmo_cnt;
  logic [31:0] avail;
  logic [31:0] total;

  // Bus decode
  wire        access   = psel & penable & ~pready;
  wire        complete = psel & penable & pready;
  wire        sel_cmd  = (paddr == A_CMD);
  wire        sel_stat = (paddr == A_STAT);
  wire        mapped   = sel_cmd | sel_stat | (paddr == A_NOTIFY) | (paddr == A_BUFLEN)
                       | (paddr == A_TMO) | (paddr == A_AVAIL) | (paddr == A_RELEASE)
                       | (paddr == A_IRQ_STAT) | (paddr == A_IRQ_MASK);
  wire        wr_done  = complete & pwrite;
  wire        rd_done  = complete & ~pwrite;
  wire        cmd_wr   = wr_done & sel_cmd;
  wire        do_start = cmd_wr & pwdata[CMD_START];
  wire        do_abort = cmd_wr & pwdata[CMD_ABORT];
  wire        do_poll  = cmd_wr & pwdata[CMD_POLL];
  wire        wait_req = access & pwrite & sel_cmd & pwdata[CMD_WAIT];

  // Wait end conditions
  wire        tmo_hit  = (tmo_cycles != ZERO32) & (tmo_cnt >= tmo_cycles);
  wire        wait_ok  = st.done | st.block_ready | st.overrun | st.fault;
  wire        wait_end = wait_ok | tmo_hit;
  wire        ack      = access & (~wait_req | wait_end);

  // Byte accounting
  wire        running  = (state != ST_IDLE);
  wire        beat_ok  = eng_beat & running;
  wire        rel_wr   = wr_done & (paddr == A_RELEASE);
  wire [31:0] rel_amt  = rel_wr ? ((pwdata > avail) ? avail : pwdata) : ZERO32;
  wire [31:0] add_amt  = beat_ok ? BEAT_BYTES : ZERO32;
  wire [31:0] next_avail = avail + add_amt - rel_amt;
  wire [31:0] next_total = total + add_amt;
  wire        fill_end = beat_ok & (state == ST_DMA) & (notify_size == ZERO32)
                       & (next_total >= buf_len);
  wire        blk_now  = (notify_size != ZERO32) & (next_avail >= notify_size);

  // Read mux
  wire [31:0] stat_word = (main_status & ~STAT_AUX_MASK)
                        | {16'h0000, st, 12'h000};
  wire [31:0] rd_mux =
      sel_stat                ? stat_word :
      (paddr == A_NOTIFY)     ? notify_size :
      (paddr == A_BUFLEN)     ? buf_len :
      (paddr == A_TMO)        ? tmo_cycles :
      (paddr == A_AVAIL)      ? avail :
      (paddr == A_IRQ_STAT)   ? {27'h0000000, irq_stat} :
      (paddr == A_IRQ_MASK)   ? {27'h0000000, irq_mask} : ZERO32;

  // Transfer control; abort outranks start, start outranks poll
  always_comb begin
    next_state = state;
    next_st    = st;
    if (do_abort) begin
      next_state = ST_IDLE;
      next_st    = '0;
    end else if (do_start | do_poll) begin
      next_state = do_start ? ST_DMA : ST_POLL;
      next_st    = '0;
    end else begin
      if (running & eng_overrun) begin
        next_state     = ST_IDLE;
        next_st.overrun = 1'b1;
      end
      if (running & eng_fault) begin
        next_state    = ST_IDLE;
        next_st.fault = 1'b1;
      end
      if (fill_end & ~eng_overrun & ~eng_fault) begin
        next_state   = ST_IDLE;
        next_st.done = 1'b1;
      end
      next_st.block_ready = blk_now;
    end
  end

  assign irq_ev = '{timeout:     ack & wait_req & ~wait_ok,
                    fault:       next_st.fault & ~st.fault,
                    overrun:     next_st.overrun & ~st.overrun,
                    done:        next_st.done & ~st.done,
                    block_ready: next_st.block_ready & ~st.block_ready};

  // APB answer, one wait cycle unless a wait command holds it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= ZERO32;
      pslverr <= 1'b0;
    end else if (pclken) begin
      pready  <= ack;
      prdata  <= (ack & ~pwrite) ? rd_mux : ZERO32;
      pslverr <= ack & (~mapped | (pwrite & sel_stat) | (~pwrite & sel_cmd));
    end
  end

  // Timeout counter runs only while a wait is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_cnt <= ZERO32;
    end else if (pclken) begin
      tmo_cnt <= (wait_req & ~ack) ? tmo_cnt + BEAT_BYTES[31:2] + ZERO32 + 32'h0000_0000 : ZERO32;
    end
  end

  // Setup registers; no offset register exists for this channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      notify_size <= ZERO32;
      buf_len     <= ZERO32;
      tmo_cycles  <= ZERO32;
      irq_mask    <= IRQ_MASK_RST;
    end else if (pclken & wr_done) begin
      if (paddr == A_NOTIFY)   notify_size <= pwdata;
      if (paddr == A_BUFLEN)   buf_len     <= pwdata;
      if (paddr == A_TMO)      tmo_cycles  <= pwdata;
      if (paddr == A_IRQ_MASK) irq_mask    <= pwdata[4:0];
    end
  end

  // Transfer state and byte counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      st    <= '0;
      avail <= ZERO32;
      total <= ZERO32;
    end else if (pclken) begin
      state <= next_state;
      st    <= next_st;
      avail <= (do_abort | do_start | do_poll) ? ZERO32 : next_avail;
      total <= (do_abort | do_start | do_poll) ? ZERO32 : next_total;
    end
  end

  // Engine and card side strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_run        <= 1'b0;
      aux_poll_mode  <= 1'b0;
      aux_poll_req   <= 1'b0;
      aux_room       <= 1'b0;
      aux_flush      <= 1'b0;
      card_cmd_valid <= 1'b0;
      card_cmd       <= ZERO32;
    end else if (pclken) begin
      aux_run        <= (next_state == ST_DMA);
      aux_poll_mode  <= (next_state == ST_POLL);
      aux_poll_req   <= rd_done & (paddr == A_AVAIL) & (state == ST_POLL);
      aux_room       <= (next_avail + BEAT_BYTES <= buf_len);
      aux_flush      <= do_abort;
      card_cmd_valid <= cmd_wr & ((pwdata & ~CMD_AUX_MASK) != ZERO32);
      card_cmd       <= cmd_wr ? (pwdata & ~CMD_AUX_MASK) : ZERO32;
    end
  end

  // Sticky events; a set in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
      irq      <= 1'b0;
    end else if (pclken) begin
      irq_stat <= ((rd_done & (paddr == A_IRQ_STAT)) ? '0 : irq_stat) | irq_ev;
      irq      <= ((irq_stat | irq_ev) & irq_mask) != 5'h00;
    end
  end

  // Checks
  sequence s_cmd(int unsigned b);
    cmd_wr && pwdata[b];
  endsequence

  property p_start;
    @(posedge pclk) disable iff (!presetn)
      (s_cmd(CMD_START) ##0 (!pwdata[CMD_ABORT] && pclken)) |=> aux_run && state == ST_DMA;
  endproperty

  a_start_runs: assert property (p_start) else $error("start did not run");
  a_abort_stops: assert property (@(posedge pclk) disable iff (!presetn)
      (s_cmd(CMD_ABORT) ##0 pclken) |=> !aux_run && aux_flush && avail == ZERO32)
    else $error("abort did not stop");
  a_poll_mode: assert property (@(posedge pclk) disable iff (!presetn)
      (s_cmd(CMD_POLL) ##0 (!pwdata[CMD_START] && !pwdata[CMD_ABORT] && pclken))
      |=> aux_poll_mode && !aux_run)
    else $error("poll mode not set");
  a_overrun_halt: assert property (@(posedge pclk) disable iff (!presetn)
      (running && eng_overrun && !cmd_wr && pclken) |=> !aux_run && st.overrun)
    else $error("overrun did not halt");
  a_fault_flag: assert property (@(posedge pclk) disable iff (!presetn)
      (running && eng_fault && !cmd_wr && pclken) |=> st.fault && state == ST_IDLE)
    else $error("fault not flagged");
  a_done_zero: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(st.done) |-> notify_size == ZERO32)
    else $error("done with nonzero notify");
  a_block_level: assert property (@(posedge pclk) disable iff (!presetn)
      st.block_ready |-> notify_size != ZERO32 && avail >= notify_size)
    else $error("block ready without data");
  a_stat_read: assert property (@(posedge pclk) disable iff (!presetn)
      (ack && !pwrite && sel_stat && pclken) |=> pready && prdata[15:12] == $past(st))
    else $error("status read wrong");
  a_wait_holds: assert property (@(posedge pclk) disable iff (!presetn)
      (wait_req && !wait_end) |=> !pready)
    else $error("wait released early");
  a_wait_timeout: assert property (@(posedge pclk) disable iff (!presetn)
      (wait_req && pclken && tmo_cycles == 32'h0000_0003 && !pready && tmo_cnt == ZERO32)
      |-> ##[1:4] pready || !pclken || !psel)
    else $error("wait timeout missed");
  a_card_cmd: assert property (@(posedge pclk) disable iff (!presetn)
      (cmd_wr && pclken) |=> card_cmd == ($past(pwdata) & ~CMD_AUX_MASK))
    else $error("card bits lost");
  a_stat_refuse: assert property (@(posedge pclk) disable iff (!presetn)
      (ack && pwrite && sel_stat && pclken) |=> pready && pslverr)
    else $error("status write not refused");
  a_cmd_refuse: assert property (@(posedge pclk) disable iff (!presetn)
      (ack && !pwrite && sel_cmd && pclken) |=> pslverr && prdata == ZERO32)
    else $error("command read not refused");
  a_cmd_nostore: assert property (@(posedge pclk) disable iff (!presetn)
      (!cmd_wr && pclken) |=> !card_cmd_valid && card_cmd == ZERO32)
    else $error("command bits held");
  a_flush_idle: assert property (@(posedge pclk) disable iff (!presetn)
      aux_flush |-> !aux_run && !aux_poll_mode)
    else $error("flush while moving");
  a_done_stops: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(st.done) |-> !aux_run && state == ST_IDLE)
    else $error("done without stop");
  a_fault_halt: assert property (@(posedge pclk) disable iff (!presetn)
      (running && eng_fault && !cmd_wr && pclken) |=> !aux_run && !aux_poll_mode)
    else $error("fault did not halt");
  // Only a wait command may stretch an access
  a_plain_ack: assert property (@(posedge pclk) disable iff (!presetn)
      (access && !wait_req && pclken) |=> pready)
    else $error("plain access stretched");

endmodule : efdc_ctrl

`default_nettype wire

// File: verification/efdc_eng_model.sv
// Purpose: Behavioural busmaster engine standing behind the aux control block
// Assumes: Same clock as the block; one beat moves one 4-byte word
// Notes:   Slow mode leaves a gap after each beat to stretch the transfer
`timescale 1ns/1ps
`default_nettype none
module efdc_eng_model (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control from the block, and the bench's slow switch
  input  wire logic aux_run,
  input  wire logic aux_room,
  input  wire logic aux_poll_req,
  input  wire logic aux_flush,
  input  wire logic slow,
  // Data movement report
  output logic      eng_beat
);
  wire logic go;
  // Card to host only; no way to move data backwards
  assign go = aux_run && aux_room && !aux_flush;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng_beat <= 1'b0;
    end else begin
      // Poll request yields one word on demand
      eng_beat <= (go && !(slow && eng_beat)) || aux_poll_req;
    end
  end
endmodule : efdc_eng_model
`default_nettype wire

// File: verification/extra_fifo_dma_control_tb_top.sv
// Purpose: Self-checking bench for the aux transfer command and status words
// Assumes: APB master per protocol; engine model on the far side
// Notes:   Live outputs are looked at on the falling edge, away from updates
`timescale 1ns/1ps
`default_nettype none
module extra_fifo_dma_control_tb_top;
  import efdc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, eng_overrun, eng_fault, slow;
  logic        err, flush_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, main_status, rd, card_seen;
  wire logic   pready, pslverr, ccv, aux_run, pmode, preq, room, flush, irq, beat;
  wire logic [31:0] prdata, card_cmd;
  int          failures, cmp_count;

  efdc_ctrl dut_u (.pclk(pclk), .presetn(presetn), .pclken(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .main_status(main_status), .card_cmd_valid(ccv),
    .card_cmd(card_cmd), .eng_beat(beat), .eng_overrun(eng_overrun), .eng_fault(eng_fault),
    .aux_run(aux_run), .aux_poll_mode(pmode), .aux_poll_req(preq), .aux_room(room),
    .aux_flush(flush), .irq(irq));
  efdc_eng_model eng_u (.pclk(pclk), .presetn(presetn), .aux_run(aux_run),
    .aux_room(room), .aux_poll_req(preq), .aux_flush(flush), .slow(slow), .eng_beat(beat));

  // Pulses are caught here so the sequence need not hit the exact cycle
  always @(posedge pclk) begin
    if (ccv === 1'b1) card_seen <= card_cmd;
    if (flush === 1'b1) flush_seen <= 1'b1;
  end

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic wrap_up;
    $display("Comparisons %0d, failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Wait commands stretch the access, so the bound is generous
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 400);
    if (pready !== 1'b1) begin
      failures++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic pulse_in(input logic ovr);
    @(posedge pclk);
    if (ovr) eng_overrun <= 1'b1; else eng_fault <= 1'b1;
    @(posedge pclk);
    eng_overrun <= 1'b0; eng_fault <= 1'b0;
    repeat (2) @(negedge pclk);
  endtask : pulse_in

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; main_status = 32'h0000_0005; eng_overrun = 1'b0; eng_fault = 1'b0;
    slow = 1'b1; failures = 0; cmp_count = 0; flush_seen = 1'b0; card_seen = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({aux_run, pmode, irq, ccv}, 32'h0);
    apb(1'b0, A_STAT, 32'h0); chk(rd, 32'h0000_0005);
    apb(1'b1, A_STAT, 32'hffff_ffff); chk(err, 32'h1);
    apb(1'b0, A_CMD, 32'h0); chk(err, 32'h1);
    apb(1'b0, 12'h004, 32'h0); chk(err, 32'h1);
    // Buffer defined before start, engine slow
    apb(1'b1, A_NOTIFY, 32'h0);
    apb(1'b1, A_BUFLEN, 32'h10);
    apb(1'b1, A_CMD, 32'h0010_0000);
    apb(1'b1, A_CMD, 32'h0020_0000);
    apb(1'b0, A_STAT, 32'h0); chk(rd, 32'h0000_2005);
    apb(1'b0, A_AVAIL, 32'h0); chk(rd, 32'h10);
    slow <= 1'b0;
    apb(1'b1, A_NOTIFY, 32'h8);
    apb(1'b1, A_BUFLEN, 32'h40);
    apb(1'b1, A_CMD, 32'h0010_0000);
    apb(1'b1, A_CMD, 32'h0020_0000);
    apb(1'b0, A_STAT, 32'h0); chk(rd, 32'h0000_1005);
    apb(1'b1, A_CMD, 32'h0040_0003);
    repeat (2) @(negedge pclk);
    chk(card_seen, 32'h3);
    chk({flush_seen, aux_run}, 32'h2);
    apb(1'b0, A_STAT, 32'h0); chk(rd, 32'h0000_0005);
    apb(1'b1, A_NOTIFY, 32'h0);
    apb(1'b1, A_BUFLEN, 32'h400);
    apb(1'b1, A_CMD, 32'h0010_0000);
    pulse_in(1'b1);
    chk({aux_run, irq}, 32'h0);
    apb(1'b0, A_STAT, 32'h0); chk(rd, 32'h0000_4005);
    apb(1'b1, A_CMD, 32'h0010_0000);
    pulse_in(1'b0);
    apb(1'b0, A_STAT, 32'h0); chk(rd, 32'h0000_8005);
    // Timeout with only its interrupt unmasked
    apb(1'b1, A_CMD, 32'h0040_0000);
    apb(1'b0, A_IRQ_STAT, 32'h0);
    apb(1'b1, A_TMO, 32'h3);
    apb(1'b1, A_IRQ_MASK, 32'h10);
    apb(1'b1, A_CMD, 32'h0020_0000);
    repeat (2) @(negedge pclk);
    chk(irq, 32'h1);
    apb(1'b0, A_IRQ_STAT, 32'h0); chk(rd & 32'h10, 32'h10);
    repeat (2) @(negedge pclk);
    chk(irq, 32'h0);
    apb(1'b1, A_CMD, 32'h0080_0000);
    @(negedge pclk);
    chk({pmode, aux_run}, 32'h2);
    apb(1'b0, A_AVAIL, 32'h0);
    repeat (4) @(negedge pclk);
    apb(1'b0, A_AVAIL, 32'h0); chk(rd, 32'h4);
    wrap_up();
  end
endmodule : extra_fifo_dma_control_tb_top
`default_nettype wire
